// *** crr_pkg.sv ***
// Shared widths, opcodes and carriers for the logic/return/rotate executor.
package crr_pkg;

  localparam int unsigned CRR_DATA_W = 8;
  localparam int unsigned CRR_ADDR_W = 8;
  localparam int unsigned CRR_PC_W   = 12;

  localparam logic [CRR_DATA_W-1:0] CRR_WREG_RST = 8'h00;
  localparam logic [CRR_PC_W-1:0]   CRR_PC_RST   = 12'h000;
  localparam logic [CRR_ADDR_W-1:0] CRR_ADDR_RST = 8'h00;
  localparam logic                  CRR_ZERO_RST = 1'b0;
  localparam logic                  CRR_MIE_RST  = 1'b0;
  localparam logic                  CRR_PULSE_RST = 1'b0;
  localparam logic [CRR_DATA_W-1:0] CRR_ZERO_VAL = 8'h00;
  localparam int unsigned           CRR_MSB      = CRR_DATA_W - 1;

  typedef enum logic [2:0] {
    CRR_OP_NONE     = 3'b000,
    CRR_OP_OR_IMM   = 3'b001,
    CRR_OP_OR_MEM   = 3'b010,
    CRR_OP_SUB_EXIT = 3'b011,
    CRR_OP_EXIT_IMM = 3'b100,
    CRR_OP_INT_EXIT = 3'b101,
    CRR_OP_ROT_LEFT = 3'b110
  } crr_op_e;

  typedef struct packed {
    crr_op_e               op;
    logic [CRR_DATA_W-1:0] imm;
    logic [CRR_ADDR_W-1:0] addr;
    logic [CRR_DATA_W-1:0] mem_rdata;
    logic [CRR_PC_W-1:0]   stack_pc;
  } crr_req_s;

  typedef struct packed {
    logic                  we;
    logic [CRR_ADDR_W-1:0] addr;
    logic [CRR_DATA_W-1:0] data;
  } crr_mem_wr_s;

endpackage

// *** crr_exec.sv ***
// Executor for OR, the three return forms and rotate left of a memory byte.
// Function
// - Immediate OR puts working register OR immediate into the register.
// - OR-to-memory writes register OR memory byte back to that byte.
// - Subroutine exit loads the PC from the stack top, flags untouched.
// - Exit with immediate pops the PC and loads the immediate, no flags.
// - Interrupt exit pops the PC and sets the master interrupt enable.
// - A pending interrupt at interrupt exit is taken before main code.
// - Rotate left moves each bit up one and old bit 7 into bit 0.
// - With the master enable clear no interrupt is taken.
`timescale 1ns/1ps
module crr_exec
  import crr_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  exec_valid_i,
  input  wire crr_req_s              req_i,
  input  wire logic                  irq_pend_i,
  output logic                       exec_ready_o,
  output logic                       irq_take_o,
  output logic [CRR_DATA_W-1:0]      wreg_o,
  output logic                       zero_o,
  output logic                       mie_o,
  output logic                       pc_load_o,
  output logic [CRR_PC_W-1:0]        pc_o,
  output logic                       stack_pop_o,
  output crr_mem_wr_s                mem_wr_o
);

  // Only byte-wide operands are served; the carriers fix the other widths.
  if (CRR_DATA_W != 8) begin : g_bad_data_w
    $error("crr_exec: data width must be eight bits");
  end
  if (CRR_PC_W < 1 || CRR_ADDR_W < 1) begin : g_bad_addr_w
    $error("crr_exec: address and counter widths must be nonzero");
  end

  logic rstn_meta_q;
  logic rstn_sync_q;

  // Reset is released through two flops so that no register leaves reset on
  // an edge close to the pin changing; assertion stays asynchronous.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rstn_meta_q <= 1'b0;
      rstn_sync_q <= 1'b0;
    end else begin
      rstn_meta_q <= 1'b1;
      rstn_sync_q <= rstn_meta_q;
    end
  end

  logic [CRR_DATA_W-1:0] wreg_q;
  logic                  zero_q;
  logic                  mie_q;
  logic                  pc_load_q;
  logic [CRR_PC_W-1:0]   pc_q;
  crr_mem_wr_s           mem_wr_q;

  wire fire        = exec_valid_i & exec_ready_o;
  wire is_orimm    = fire & (req_i.op == CRR_OP_OR_IMM);
  wire is_ormem    = fire & (req_i.op == CRR_OP_OR_MEM);
  wire is_sub_exit = fire & (req_i.op == CRR_OP_SUB_EXIT);
  wire is_exit_imm = fire & (req_i.op == CRR_OP_EXIT_IMM);
  wire is_int_exit = fire & (req_i.op == CRR_OP_INT_EXIT);
  wire is_rot      = fire & (req_i.op == CRR_OP_ROT_LEFT);
  wire is_or       = is_orimm | is_ormem;
  wire is_pop      = is_sub_exit | is_exit_imm | is_int_exit;
  wire is_mem_wr   = is_ormem | is_rot;

  logic [CRR_DATA_W-1:0] or_imm_w;
  logic [CRR_DATA_W-1:0] or_mem_w;
  logic [CRR_DATA_W-1:0] rot_w;

  // Rotate wraps the top bit round to bit zero, so bit zero has its own arm.
  for (genvar b = 0; b < CRR_DATA_W; b++) begin : g_bit
    assign or_imm_w[b] = wreg_q[b] | req_i.imm[b];
    assign or_mem_w[b] = wreg_q[b] | req_i.mem_rdata[b];
    if (b == 0) begin : g_wrap
      assign rot_w[b] = req_i.mem_rdata[CRR_MSB];
    end else begin : g_shift
      assign rot_w[b] = req_i.mem_rdata[b-1];
    end
  end

  wire [CRR_DATA_W-1:0] or_res_w = is_ormem ? or_mem_w : or_imm_w;
  wire                  or_zero  = (or_res_w == CRR_ZERO_VAL);

  // An interrupt is only taken with the enable set; while it is taken no
  // main instruction may issue, which is what lets a pending request win
  // straight after an interrupt exit.
  assign irq_take_o   = mie_q & irq_pend_i;
  assign exec_ready_o = ~irq_take_o;

  // Only the immediate OR and the exit with immediate load the register.
  wire [CRR_DATA_W-1:0] wreg_ld_w =
    is_exit_imm ? req_i.imm : wreg_q;
  wire [CRR_DATA_W-1:0] wreg_d =
    is_orimm ? or_imm_w : wreg_ld_w;
  wire zero_d = is_or ? or_zero : zero_q;
  // Interrupt entry clears the enable so nested requests wait for the exit.
  wire mie_d =
    is_int_exit ? 1'b1 : (irq_take_o ? 1'b0 : mie_q);

  crr_mem_wr_s mem_wr_d;
  assign mem_wr_d.we   = is_mem_wr;
  assign mem_wr_d.addr = is_mem_wr ? req_i.addr : mem_wr_q.addr;
  assign mem_wr_d.data = is_rot ? rot_w :
                         (is_ormem ? or_mem_w : mem_wr_q.data);

  wire [CRR_PC_W-1:0] pc_d = is_pop ? req_i.stack_pc : pc_q;

  always_ff @(posedge clk_i or negedge rstn_sync_q) begin
    if (!rstn_sync_q) begin
      wreg_q    <= CRR_WREG_RST;
      zero_q    <= CRR_ZERO_RST;
      mie_q     <= CRR_MIE_RST;
      pc_load_q <= CRR_PULSE_RST;
      pc_q      <= CRR_PC_RST;
      mem_wr_q  <= '{we:   CRR_PULSE_RST,
                     addr: CRR_ADDR_RST,
                     data: CRR_ZERO_VAL};
    end else begin
      wreg_q    <= wreg_d;
      zero_q    <= zero_d;
      mie_q     <= mie_d;
      pc_load_q <= is_pop;
      pc_q      <= pc_d;
      mem_wr_q  <= mem_wr_d;
    end
  end

  assign wreg_o      = wreg_q;
  assign zero_o      = zero_q;
  assign mie_o       = mie_q;
  assign pc_load_o   = pc_load_q;
  assign pc_o        = pc_q;
  assign stack_pop_o = is_pop;
  assign mem_wr_o    = mem_wr_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_sync_q);

  or_imm_a: assert property (
      is_orimm |=> wreg_q == ($past(wreg_q) | $past(req_i.imm)))
    else $error("immediate OR result wrong");
  or_mem_a: assert property (
      is_ormem |=> mem_wr_q.we && $stable(wreg_q) &&
      mem_wr_q.data == ($past(wreg_q) | $past(req_i.mem_rdata)))
    else $error("memory OR write wrong");
  mem_addr_a: assert property (
      is_mem_wr |=> mem_wr_q.addr == $past(req_i.addr))
    else $error("memory write address wrong");
  wreg_hold_a: assert property (
      !is_orimm && !is_exit_imm |=> $stable(wreg_q))
    else $error("working register changed unexpectedly");

  sub_exit_a: assert property (
      is_sub_exit |=> pc_load_q && pc_q == $past(req_i.stack_pc) &&
      $stable(zero_q) && $stable(wreg_q))
    else $error("subroutine exit wrong");
  pc_hold_a: assert property (
      !is_pop |=> !pc_load_q && $stable(pc_q))
    else $error("program counter moved without a return");
  zero_hold_a: assert property (
      !is_or |=> $stable(zero_q))
    else $error("zero flag changed outside OR");
  exit_imm_a: assert property (
      is_exit_imm |=> pc_load_q && pc_q == $past(req_i.stack_pc) &&
      wreg_q == $past(req_i.imm) && $stable(zero_q))
    else $error("exit with immediate wrong");
  int_exit_a: assert property (
      is_int_exit |=> mie_q && pc_load_q &&
      pc_q == $past(req_i.stack_pc) && $stable(zero_q))
    else $error("interrupt exit did not set enable");

  pend_first_a: assert property (
      is_int_exit && irq_pend_i ##1 irq_pend_i |->
      irq_take_o && !exec_ready_o)
    else $error("pending interrupt not taken first");
  refuse_a: assert property (
      irq_take_o |=> $stable(wreg_q) && $stable(zero_q) &&
      !pc_load_q && !mem_wr_q.we)
    else $error("instruction executed during interrupt entry");

  rot_left_a: assert property (
      is_rot |=> mem_wr_q.we && $stable(zero_q) &&
      mem_wr_q.data == {$past(req_i.mem_rdata[CRR_MSB-1:0]),
                        $past(req_i.mem_rdata[CRR_MSB])})
    else $error("rotate left result wrong");
  mem_pulse_a: assert property (
      !is_mem_wr |=> !mem_wr_q.we)
    else $error("memory write outside OR or rotate");
  mem_hold_a: assert property (
      !is_mem_wr |=> $stable(mem_wr_q.addr) && $stable(mem_wr_q.data))
    else $error("memory write fields changed while idle");

  mie_gate_a: assert property (
      !mie_q |-> !irq_take_o)
    else $error("interrupt taken with enable clear");
  mie_hold_a: assert property (
      !mie_q && !is_int_exit |=> !mie_q)
    else $error("enable set by something other than interrupt exit");
  mie_clear_a: assert property (
      irq_take_o |=> !mie_q)
    else $error("enable still set after interrupt entry");

  zero_imm_a: assert property (
      is_orimm |=> zero_q == (wreg_q == CRR_ZERO_VAL))
    else $error("zero flag wrong after immediate OR");
  zero_mem_a: assert property (
      is_ormem |=> zero_q == (mem_wr_q.data == CRR_ZERO_VAL))
    else $error("zero flag wrong after memory OR");

  cov_or_zero_c: cover property (is_or && or_zero);
  cov_pend_c: cover property (is_int_exit && irq_pend_i ##1 irq_take_o);
  cov_rot_c: cover property (is_rot && req_i.mem_rdata[CRR_MSB]);
  cov_exit_imm_c: cover property (is_exit_imm ##1 is_orimm);
  cov_ormem_c: cover property (is_ormem ##1 is_sub_exit);

endmodule

// *** crr_tb.sv ***
// Self-checking testbench for the logic, return and rotate executor.
`timescale 1ns/1ps
module testbench;
  import crr_pkg::*;
  logic        clk_i        = 1'b0;
  logic        rstn_i       = 1'b0;
  logic        exec_valid_i = 1'b0;
  crr_req_s    req_i        = '0;
  logic        irq_pend_i   = 1'b0;
  logic        exec_ready_o, irq_take_o, zero_o, mie_o, pc_load_o;
  logic        stack_pop_o;
  logic [7:0]  wreg_o;
  logic [11:0] pc_o;
  crr_mem_wr_s mem_wr_o;
  int          miscompares  = 0;
  int          checks_done  = 0;

  crr_exec DUT (.clk_i(clk_i), .rstn_i(rstn_i), .exec_valid_i(exec_valid_i),
    .req_i(req_i), .irq_pend_i(irq_pend_i), .exec_ready_o(exec_ready_o),
    .irq_take_o(irq_take_o), .wreg_o(wreg_o), .zero_o(zero_o), .mie_o(mie_o),
    .pc_load_o(pc_load_o), .pc_o(pc_o), .stack_pop_o(stack_pop_o),
    .mem_wr_o(mem_wr_o));

  always #5 clk_i = ~clk_i;

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One instruction; results are sampled half a cycle after the taking edge, on the falling edge.
  task automatic run(crr_op_e op, logic [7:0] imm, logic [7:0] rd,
                     logic [11:0] pc);
    logic pops;
    pops = op inside {CRR_OP_SUB_EXIT, CRR_OP_EXIT_IMM, CRR_OP_INT_EXIT};
    @(posedge clk_i);
    exec_valid_i <= 1'b1;
    req_i <= '{op: op, imm: imm, addr: 8'h33, mem_rdata: rd, stack_pc: pc};
    @(negedge clk_i);
    chk("stack_pop", {15'h0, pops}, {15'h0, stack_pop_o});
    @(posedge clk_i);
    exec_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic t_or;
    run(CRR_OP_OR_IMM, 8'h00, 8'h00, 12'h000);
    chk("zero", 16'h1, zero_o);
    run(CRR_OP_OR_IMM, 8'h5A, 8'h00, 12'h000);
    chk("wreg", 16'h5A, wreg_o);
    chk("zero", 16'h0, zero_o);
    run(CRR_OP_OR_MEM, 8'h00, 8'h81, 12'h000);
    chk("mem_we", 16'h1, mem_wr_o.we);
    chk("mem_addr", 16'h33, mem_wr_o.addr);
    chk("mem_data", 16'hDB, mem_wr_o.data);
    chk("wreg", 16'h5A, wreg_o);
  endtask

  task automatic t_rot;
    run(CRR_OP_ROT_LEFT, 8'h00, 8'h81, 12'h000);
    chk("mem_data", 16'h03, mem_wr_o.data);
    chk("mem_we", 16'h1, mem_wr_o.we);
    chk("mem_addr", 16'h33, mem_wr_o.addr);
    @(negedge clk_i);
    chk("mem_we", 16'h0, mem_wr_o.we);
    run(CRR_OP_NONE, 8'hFF, 8'hFF, 12'hFFF);
    chk("wreg", 16'h5A, wreg_o);
    chk("pc_load", 16'h0, pc_load_o);
    chk("mem_we", 16'h0, mem_wr_o.we);
  endtask

  task automatic t_ret;
    run(CRR_OP_SUB_EXIT, 8'hFF, 8'h00, 12'hABC);
    chk("pc_load", 16'h1, pc_load_o);
    chk("pc", 16'hABC, pc_o);
    chk("wreg", 16'h5A, wreg_o);
    run(CRR_OP_EXIT_IMM, 8'h00, 8'h00, 12'h123);
    chk("pc_load", 16'h1, pc_load_o);
    chk("pc", 16'h123, pc_o);
    chk("wreg", 16'h00, wreg_o);
    chk("zero", 16'h0, zero_o);
  endtask

  // A pending request waits for the enable, then wins over main code.
  task automatic t_irq;
    @(posedge clk_i);
    irq_pend_i <= 1'b1;
    @(negedge clk_i);
    chk("irq_take", 16'h0, irq_take_o);
    chk("ready", 16'h1, exec_ready_o);
    @(posedge clk_i);
    exec_valid_i <= 1'b1;
    req_i <= '{op: CRR_OP_INT_EXIT, imm: 8'h00, addr: 8'h33,
               mem_rdata: 8'h00, stack_pc: 12'h7E5};
    @(posedge clk_i);
    req_i.op <= CRR_OP_OR_IMM;
    req_i.imm <= 8'hFF;
    @(negedge clk_i);
    chk("mie", 16'h1, mie_o);
    chk("pc", 16'h7E5, pc_o);
    chk("irq_take", 16'h1, irq_take_o);
    chk("ready", 16'h0, exec_ready_o);
    @(posedge clk_i);
    exec_valid_i <= 1'b0;
    @(negedge clk_i);
    chk("wreg", 16'h00, wreg_o);
    chk("mie", 16'h0, mie_o);
    chk("irq_take", 16'h0, irq_take_o);
    @(posedge clk_i);
    irq_pend_i <= 1'b0;
  endtask

  // A reset in mid-run must clear the state and let execution resume.
  task automatic t_reset;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i);
    chk("pc", 16'h000, pc_o);
    chk("mem_addr", 16'h00, mem_wr_o.addr);
    chk("mem_data", 16'h00, mem_wr_o.data);
    chk("ready", 16'h1, exec_ready_o);
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    run(CRR_OP_OR_IMM, 8'h24, 8'h00, 12'h000);
    chk("wreg", 16'h24, wreg_o);
    chk("zero", 16'h0, zero_o);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_or();
    t_rot();
    t_ret();
    t_irq();
    t_reset();
    results();
  end
endmodule
